/* File: inc/uart_pkg.sv */
/*
  Shared constants and types for the serial port with address filter:
  bit timing, control register layout, modes, states and the state record.
  Assumes a single 25 MHz system clock domain.
*/
package uart_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ    = 25_000_000;
  localparam int unsigned BAUD_HZ   = 115_200;
  localparam logic [15:0] BIT_M0    = 16'h000c;
  localparam logic [15:0] BIT_M2    = 16'h0040;
  localparam logic [15:0] BIT_M13   = 16'(CLK_HZ / BAUD_HZ);

  // ----------------------------------------------------------------
  // transmit buffer and frame lengths
  // ----------------------------------------------------------------
  localparam int          FIFO_W     = 9;
  localparam int          FIFO_DEPTH = 4;
  localparam logic [3:0]  NBITS_M0   = 4'h8;
  localparam logic [3:0]  NBITS_M1   = 4'ha;
  localparam logic [3:0]  NBITS_M23  = 4'hb;
  localparam logic [3:0]  LAST_M0    = 4'h7;
  localparam logic [3:0]  LAST_M1    = 4'h8;
  localparam logic [3:0]  LAST_M23   = 4'h9;

  // ----------------------------------------------------------------
  // serial_control_reg field positions
  // ----------------------------------------------------------------
  localparam int CTL_B7  = 7;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_MP_EN   = 5;
  localparam int CTL_REN = 4;
  localparam int CTL_TB8 = 3;
  localparam int CTL_RB8 = 2;
  localparam int CTL_TI  = 1;
  localparam int CTL_RX_DONE = 0;

  typedef enum logic [1:0] {
    M_SHIFT = 2'b00,
    M_UART8 = 2'b01,
    M_FIX9  = 2'b10,
    M_VAR9  = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    T_IDLE  = 2'b00,
    T_SHIFT = 2'b01
  } tx_state_t;

  typedef enum logic [1:0] {
    R_IDLE  = 2'b00,
    R_START = 2'b01,
    R_DATA  = 2'b10,
    R_SYNC  = 2'b11
  } rx_state_t;

  typedef struct packed {
    logic wr;
    logic [7:0] wdata;
  } wr_req_t;

  typedef struct packed {
    logic mode_spec_hi;
    logic mode_spec_lo;
    logic multiproc_enable;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic receive_complete_flag;
    logic framing_error_flag;
  } ctl_t;

  typedef struct packed {
    ctl_t        ctl;
    logic [7:0]  rxbuf;
    tx_state_t   tst;
    logic [15:0] tcnt;
    logic [3:0]  tbits;
    logic [10:0] tsh;
    rx_state_t   rst;
    logic [15:0] rcnt;
    logic [3:0]  rbits;
    logic [9:0]  rsh;
    logic        sync1;
    logic        sync2;
    logic        prev;
    logic [7:0]  rd;
    logic        irq;
    logic        txd;
    logic        rxo;
    logic        rxoe;
  } uart_state_t;

  localparam uart_state_t UART_RST = '{
    ctl: '0, rxbuf: 8'h00, tst: T_IDLE, tcnt: 16'h0000, tbits: 4'h0,
    tsh: 11'h7ff, rst: R_IDLE, rcnt: 16'h0000, rbits: 4'h0, rsh: 10'h000,
    sync1: 1'b1, sync2: 1'b1, prev: 1'b1, rd: 8'h00, irq: 1'b0,
    txd: 1'b1, rxo: 1'b1, rxoe: 1'b0};

  function automatic logic [15:0] bit_cycles(input mode_t m);
    case (m)
      M_SHIFT: bit_cycles = BIT_M0;
      M_FIX9:  bit_cycles = BIT_M2;
      default: bit_cycles = BIT_M13;
    endcase
  endfunction

endpackage

/* File: verilog/word_fifo.sv */
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock; the ready on the write side is registered.
*/
module word_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic          rdy;
  } fifo_state_t;

  fifo_state_t   st_r;
  fifo_state_t   st_nxt;
  logic [W-1:0]  mem [DEPTH];
  logic          push;
  logic          pop;

  assign in_ready  = st_r.rdy;
  assign out_valid = st_r.cnt != '0;
  assign out_data  = mem[st_r.rp];

  // ----------------------------------------------------------------
  // pointers and fill level
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    push   = in_valid & st_r.rdy;
    pop    = out_ready & (st_r.cnt != '0);
    if (push) begin
      st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + AW'(1);
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + AW'(1);
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - CW'(1);
    end
    st_nxt.rdy = st_nxt.cnt != CW'(DEPTH);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[st_r.wp] <= in_data;
    end
  end

endmodule

/* File: verilog/uart_addr_filter.sv */
/*
  Four-mode serial port, full-duplex except in mode 0, with framing check and hardware
  address filtering. Transmit words pass through a 4-word FIFO.
  Assumes control inputs are synchronous to clk_sys; rxd_in is async.
*/
module uart_addr_filter (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  uart_pkg::wr_req_t    serial_data_wr,
  output logic                 serial_data_ready,
  output logic [7:0]           serial_data_port,
  input  uart_pkg::wr_req_t    ctl_wr,
  output logic [7:0]           serial_control_reg,
  input  wire logic            bit7_select,
  input  wire logic [7:0]      individual_address_reg,
  input  wire logic [7:0]      address_mask_reg,
  output logic                 serial_irq,
  output logic                 txd,
  input  wire logic            rxd_in,
  output logic                 rxd_out,
  output logic                 rxd_oe
);

  uart_pkg::uart_state_t st_r;
  uart_pkg::uart_state_t n;
  uart_pkg::mode_t       mode;
  logic [15:0]           per;
  logic [15:0]           half;
  logic [9:0]            sh;
  logic [7:0]            rx_byte;
  logic                  rx_ninth;
  logic                  rx_stop;
  logic [7:0]            bcast_mask;
  logic                  given_hit;
  logic                  bcast_hit;
  logic                  accept;
  logic                  pop;
  logic                  fifo_valid;
  logic [8:0]            fifo_data;

  // ----------------------------------------------------------------
  // transmit buffer
  // ----------------------------------------------------------------
  word_fifo #(
    .W     (uart_pkg::FIFO_W),
    .DEPTH (uart_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (serial_data_wr.wr),
    .in_ready  (serial_data_ready),
    .in_data   ({serial_data_wr.wdata, st_r.ctl.tb8}),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  assign serial_data_port   = st_r.rxbuf;
  assign serial_control_reg = st_r.rd;
  assign serial_irq         = st_r.irq;
  assign txd                = st_r.txd;
  assign rxd_out            = st_r.rxo;
  assign rxd_oe             = st_r.rxoe;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n          = st_r;
    mode       = uart_pkg::mode_t'({st_r.ctl.mode_spec_hi, st_r.ctl.mode_spec_lo});
    per        = uart_pkg::bit_cycles(mode);
    half       = {1'b0, per[15:1]};
    pop        = 1'b0;
    sh         = {st_r.sync2, st_r.rsh[9:1]};
    rx_byte    = sh[7:0];
    rx_ninth   = sh[8];
    rx_stop    = sh[9];
    accept     = 1'b0;
    bcast_mask = individual_address_reg | address_mask_reg;

    // rxd_in synchroniser; only sync2 and its delayed copy prev are read by logic
    n.sync1 = rxd_in;
    n.sync2 = st_r.sync1;
    n.prev  = st_r.sync2;

    // control register write; bit 7 steered by select
    if (ctl_wr.wr) begin
      if (bit7_select) begin
        n.ctl.framing_error_flag = ctl_wr.wdata[uart_pkg::CTL_B7];
      end else begin
        n.ctl.mode_spec_hi = ctl_wr.wdata[uart_pkg::CTL_B7];
      end
      n.ctl.mode_spec_lo          = ctl_wr.wdata[uart_pkg::CTL_MODE_LO];
      n.ctl.multiproc_enable      = ctl_wr.wdata[uart_pkg::CTL_MP_EN];
      n.ctl.ren                   = ctl_wr.wdata[uart_pkg::CTL_REN];
      n.ctl.tb8                   = ctl_wr.wdata[uart_pkg::CTL_TB8];
      n.ctl.rb8                   = ctl_wr.wdata[uart_pkg::CTL_RB8];
      n.ctl.ti                    = ctl_wr.wdata[uart_pkg::CTL_TI];
      n.ctl.receive_complete_flag = ctl_wr.wdata[uart_pkg::CTL_RX_DONE];
    end

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    case (st_r.tst)
      uart_pkg::T_IDLE: begin
        // mode 0 shares rxd, so wait for a receive to finish
        if (fifo_valid && (mode != uart_pkg::M_SHIFT || st_r.rst == uart_pkg::R_IDLE)) begin
          pop    = 1'b1;
          n.tst  = uart_pkg::T_SHIFT;
          n.tcnt = '0;
          case (mode)
            uart_pkg::M_SHIFT: begin
              n.tsh   = {3'b111, fifo_data[8:1]};
              n.tbits = uart_pkg::NBITS_M0;
            end
            uart_pkg::M_UART8: begin
              n.tsh   = {2'b11, fifo_data[8:1], 1'b0};
              n.tbits = uart_pkg::NBITS_M1;
            end
            default: begin
              n.tsh   = {1'b1, fifo_data[0], fifo_data[8:1], 1'b0};
              n.tbits = uart_pkg::NBITS_M23;
            end
          endcase
        end
      end
      uart_pkg::T_SHIFT: begin
        if (st_r.tcnt == per - 16'h0001) begin
          n.tcnt  = '0;
          n.tsh   = {1'b1, st_r.tsh[10:1]};
          n.tbits = st_r.tbits - 4'h1;
          if (st_r.tbits == 4'h1) begin
            n.tst    = uart_pkg::T_IDLE;
            n.ctl.ti = 1'b1;
          end
        end else begin
          n.tcnt = st_r.tcnt + 16'h0001;
        end
      end
      default: begin
        n.tst = uart_pkg::T_IDLE;
      end
    endcase

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    case (st_r.rst)
      uart_pkg::R_IDLE: begin
        if (mode == uart_pkg::M_SHIFT) begin
          if (st_r.ctl.ren && !st_r.ctl.receive_complete_flag
              && st_r.tst == uart_pkg::T_IDLE && !fifo_valid) begin
            n.rst   = uart_pkg::R_SYNC;
            n.rcnt  = '0;
            n.rbits = '0;
          end
        end else if (st_r.ctl.ren && st_r.prev && !st_r.sync2) begin
          n.rst  = uart_pkg::R_START;
          n.rcnt = '0;
        end
      end
      uart_pkg::R_START: begin
        if (st_r.rcnt == half - 16'h0001) begin
          n.rcnt  = '0;
          n.rbits = '0;
          // glitch shorter than half a bit is dropped
          n.rst = st_r.sync2 ? uart_pkg::R_IDLE : uart_pkg::R_DATA;
        end else begin
          n.rcnt = st_r.rcnt + 16'h0001;
        end
      end
      uart_pkg::R_DATA: begin
        if (st_r.rcnt == per - 16'h0001) begin
          n.rcnt  = '0;
          n.rsh   = sh;
          n.rbits = st_r.rbits + 4'h1;
          if (mode == uart_pkg::M_UART8) begin
            rx_byte  = sh[8:1];
            rx_ninth = sh[9];
          end
          if (st_r.rbits == ((mode == uart_pkg::M_UART8) ? uart_pkg::LAST_M1
                                                          : uart_pkg::LAST_M23)) begin
            n.rst = uart_pkg::R_IDLE;
            if (!rx_stop) begin
              n.ctl.framing_error_flag = 1'b1;
            end
            if (mode == uart_pkg::M_UART8) begin
              accept = !st_r.ctl.multiproc_enable || rx_stop;
            end else begin
              accept = !st_r.ctl.multiproc_enable
                       || (rx_ninth && (given_hit || bcast_hit));
            end
            if (accept && !st_r.ctl.receive_complete_flag) begin
              n.rxbuf                     = rx_byte;
              n.ctl.rb8                   = rx_ninth;
              n.ctl.receive_complete_flag = 1'b1;
            end
          end
        end else begin
          n.rcnt = st_r.rcnt + 16'h0001;
        end
      end
      uart_pkg::R_SYNC: begin
        // mode 0: shift clock on txd, sample at its rising half
        if (st_r.rcnt == per - 16'h0001) begin
          n.rcnt  = '0;
          n.rsh   = sh;
          n.rbits = st_r.rbits + 4'h1;
          if (st_r.rbits == uart_pkg::LAST_M0) begin
            n.rst                       = uart_pkg::R_IDLE;
            n.rxbuf                     = sh[9:2];
            n.ctl.receive_complete_flag = 1'b1;
          end
        end else begin
          n.rcnt = st_r.rcnt + 16'h0001;
        end
      end
      default: begin
        n.rst = uart_pkg::R_IDLE;
      end
    endcase

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    n.txd  = 1'b1;
    n.rxo  = 1'b1;
    n.rxoe = 1'b0;
    if (n.tst == uart_pkg::T_SHIFT) begin
      if (mode == uart_pkg::M_SHIFT) begin
        n.txd  = n.tcnt >= half;
        n.rxo  = n.tsh[0];
        n.rxoe = 1'b1;
      end else begin
        n.txd = n.tsh[0];
      end
    end
    if (n.rst == uart_pkg::R_SYNC) begin
      n.txd = n.rcnt >= half;
    end

    // readback and interrupt
    n.rd = {bit7_select ? n.ctl.framing_error_flag : n.ctl.mode_spec_hi,
            n.ctl.mode_spec_lo, n.ctl.multiproc_enable, n.ctl.ren,
            n.ctl.tb8, n.ctl.rb8, n.ctl.ti, n.ctl.receive_complete_flag};
    n.irq = n.ctl.ti | n.ctl.receive_complete_flag;
  end

  // ----------------------------------------------------------------
  // address compare
  // ----------------------------------------------------------------
  always_comb begin
    given_hit = ((rx_byte ^ individual_address_reg) & address_mask_reg) == 8'h00;
    bcast_hit = (rx_byte & bcast_mask) == bcast_mask;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= uart_pkg::UART_RST;
    end else begin
      st_r <= n;
    end
  end

endmodule

/* File: test/uart_addr_filter_assertions.sv */
/*
  Port-level checks for the serial port with address filter.
  Bound into every uart_addr_filter; one clock, asynchronous low reset.
*/
module uart_addr_filter_checker (
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire uart_pkg::wr_req_t serial_data_wr,
  input wire logic              serial_data_ready,
  input wire logic [7:0]        serial_data_port,
  input wire uart_pkg::wr_req_t ctl_wr,
  input wire logic [7:0]        serial_control_reg,
  input wire logic              bit7_select,
  input wire logic              serial_irq,
  input wire logic              txd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] idle_cnt_r;
  logic [9:0] low_cnt_r;
  logic       mode2;
  assign mode2 = !bit7_select && serial_control_reg[7:6] == 2'h2;
  // run lengths of txd high and low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_r <= 10'h000;
      low_cnt_r  <= 10'h000;
    end else begin
      idle_cnt_r <= !txd ? 10'h000 : (&idle_cnt_r ? idle_cnt_r : idle_cnt_r + 10'h001);
      low_cnt_r  <= txd ? 10'h000 : low_cnt_r + 10'h001;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // assertions and covers
  // ----------------------------------------
  irq_level_a:
    assert property (serial_irq == (serial_control_reg[1] | serial_control_reg[0]))
    else $error("irq differs from completion flags");
  ctl_write_a:
    assert property (ctl_wr.wr |=> serial_control_reg[6:3] == $past(ctl_wr.wdata[6:3]))
    else $error("control bits not taken");
  mode_hi_a:
    assert property (ctl_wr.wr && !bit7_select ##1 !bit7_select
                     |-> serial_control_reg[7] == $past(ctl_wr.wdata[7]))
    else $error("bit 7 not mode bit with select low");
  fe_hold_a:
    assert property ($past(bit7_select) && bit7_select && serial_control_reg[7] && !ctl_wr.wr
                     ##1 bit7_select |-> serial_control_reg[7])
    else $error("framing error cleared by hardware");
  port_rx_a:
    assert property (!$stable(serial_data_port) |-> $rose(serial_control_reg[0]))
    else $error("data port changed without reception");
  ri_hold_a:
    assert property (serial_control_reg[0] && !ctl_wr.wr |=> serial_control_reg[0])
    else $error("receive flag dropped by hardware");
  tx_start_a:
    assert property (serial_data_wr.wr && serial_data_ready && mode2 && &idle_cnt_r
                     |-> ##2 !txd)
    else $error("no start bit after data write");
  bit_len_a:
    assert property ($rose(txd) && mode2 |-> low_cnt_r != 10'h000 && low_cnt_r[5:0] == 6'h00)
    else $error("low run not whole bit periods");
  rx_done_c: cover property ($rose(serial_control_reg[0]));
  full_c: cover property (!serial_data_ready);
  fe_seen_c: cover property (bit7_select && serial_control_reg[7]);
endmodule

bind uart_addr_filter uart_addr_filter_checker chk_i (
  .clk_sys, .rst_n, .serial_data_wr, .serial_data_ready, .serial_data_port,
  .ctl_wr, .serial_control_reg, .bit7_select, .serial_irq, .txd);

/* File: test/uart_peer.sv */
/*
  Far-end station on the shared receive line: framed sends and mode-0 data.
  Line idles high as if pulled up; runs on the device clock.
*/
module uart_peer (
  input wire logic clk_sys,
  input wire logic shift_clk,
  output logic     line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'h1;
  // start, nb bits lsb first, stop, then released high
  task automatic send(input logic [8:0] w, input int nb, input logic stop, input int per);
    int i;
    @(posedge clk_sys);
    line <= 1'h0;
    repeat (per) @(posedge clk_sys);
    for (i = 0; i < nb; i++) begin
      line <= w[i];
      repeat (per) @(posedge clk_sys);
    end
    line <= stop;
    repeat (per) @(posedge clk_sys);
    line <= 1'h1;
  endtask
  // one bit per shift period, changed as the period opens
  task automatic shift_in(input logic [7:0] b);
    int i;
    for (i = 0; i < 8; i++) begin
      @(negedge shift_clk);
      line <= b[i];
    end
    @(posedge shift_clk);
    repeat (8) @(posedge clk_sys);
    line <= 1'h1;
  endtask
endmodule

/* File: test/uart_addr_filter_tb.sv */
/*
  Self-checking bench for uart_addr_filter: a control port task, inline data port writes,
  a far-end station on the receive line and frame decoding on txd.
  Assumes the bound checker and uart_peer are compiled alongside.
*/
module uart_addr_filter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys = 1'h0;
  logic              rst_n = 1'h0;
  uart_pkg::wr_req_t serial_data_wr = '0;
  uart_pkg::wr_req_t ctl_wr = '0;
  logic              bit7_select = 1'h0;
  logic [7:0]        individual_address_reg = 8'hf1;
  logic [7:0]        address_mask_reg = 8'hfa;
  logic              serial_data_ready, serial_irq, txd, rxd_out, rxd_oe, peer_line;
  logic [7:0]        serial_data_port;
  logic [7:0]        serial_control_reg;
  wire               rxd_w = rxd_oe ? rxd_out : peer_line;
  int                fails = 0;
  int                samples_checked = 0;
  int                cyc = 0;
  int                i;
  int                per;
  logic [7:0]        tc [7] = '{8'hb0, 8'hb0, 8'hb0, 8'hb0, 8'h90, 8'h70, 8'hf0};
  logic [8:0]        tf [7] = '{9'h1f0, 9'h1f2, 9'h1ff, 9'h0f0, 9'h033, 9'h1f2, 9'h17b};
  logic              ts [7] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
  logic              te [7] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
  logic [8:0]        q [$];
  logic [8:0]        w;
  logic [7:0]        exp_port = 8'h3c;
  logic              refused = 1'h0;

  always #20 clk_sys = ~clk_sys;

  uart_addr_filter uut (.clk_sys, .rst_n, .serial_data_wr, .serial_data_ready,
    .serial_data_port, .ctl_wr, .serial_control_reg, .bit7_select,
    .individual_address_reg, .address_mask_reg, .serial_irq, .txd,
    .rxd_in(rxd_w), .rxd_out, .rxd_oe);
  uart_peer peer (.clk_sys, .shift_clk(txd), .line(peer_line));

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      fails++;
    end
  endtask
  task automatic ctl(input logic [7:0] v);
    @(posedge clk_sys);
    ctl_wr <= '{wr: 1'h1, wdata: v};
    @(posedge clk_sys);
    ctl_wr.wr <= 1'h0;
    @(negedge clk_sys);
  endtask
  // decode one framed word from txd, sampling mid-bit
  task automatic getf(input int per, output logic [8:0] w);
    int k;
    int j;
    k = 0;
    while (txd === 1'h1 && k < 3000) begin
      @(negedge clk_sys);
      k++;
    end
    chk(txd, 9'h000);
    repeat (per / 2) @(negedge clk_sys);
    for (j = 0; j < 10; j++) begin
      repeat (per) @(negedge clk_sys);
      if (j < 9) w[j] = txd;
    end
    chk(txd, 9'h001);
  endtask
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(negedge clk_sys);
    chk(serial_control_reg, 9'h000);
    chk(serial_data_port, 9'h000);
    chk({serial_irq, txd, serial_data_ready, rxd_oe}, 9'h006);
    fork
      peer.shift_in(8'h5a);
      ctl(8'h10);
    join
    repeat (20) @(negedge clk_sys);
    chk(serial_control_reg[0], 9'h001);
    chk(serial_data_port, 9'h05a);
    ctl(8'h98);
    repeat (1100) @(negedge clk_sys);
    // back-to-back writes past the buffer depth, receiving meanwhile
    fork
      peer.send(9'h13c, 9, 1'h1, 64);
      begin
        for (i = 0; i < 6; i++) begin
          @(posedge clk_sys);
          serial_data_wr <= '{wr: 1'h1, wdata: 8'ha5 ^ 8'(i)};
          @(negedge clk_sys);
          if (serial_data_ready) q.push_back({1'h1, 8'ha5 ^ 8'(i)});
          else refused = 1'h1;
        end
        @(posedge clk_sys);
        serial_data_wr.wr <= 1'h0;
      end
      do begin
        getf(64, w);
        chk(w, q.pop_front());
      end while (q.size() > 0);
    join
    repeat (40) @(negedge clk_sys);
    chk(refused, 9'h001);
    chk(serial_data_ready, 9'h001);
    chk(serial_data_port, 9'h03c);
    chk(serial_control_reg[2:0], 9'h007);
    chk(serial_irq, 9'h001);
    ctl(8'h90);
    chk(serial_irq, 9'h000);
    // address filter, data frames and framing error across modes
    for (i = 0; i < 7; i++) begin
      ctl(tc[i]);
      per = (tc[i][7:6] == 2'h2) ? 64 : 217;
      peer.send(tf[i], (tc[i][7:6] == 2'h1) ? 8 : 9, ts[i], per);
      repeat (4) @(negedge clk_sys);
      chk(serial_control_reg[0], te[i]);
      if (te[i]) begin
        exp_port = tf[i][7:0];
        chk(serial_control_reg[2], tf[i][8]);
      end
      chk(serial_data_port, exp_port);
    end
    @(posedge clk_sys);
    bit7_select <= 1'h1;
    repeat (2) @(negedge clk_sys);
    chk(serial_control_reg[7], 9'h001);
    repeat (100) @(negedge clk_sys);
    chk(serial_control_reg[7], 9'h001);
    ctl(8'h70);
    chk(serial_control_reg[7], 9'h000);
    @(posedge clk_sys);
    bit7_select <= 1'h0;
    repeat (2) @(negedge clk_sys);
    chk(serial_control_reg[7], 9'h001);
    // mode 0 transmit: data on rxd_out, shift clock on txd
    ctl(8'h00);
    @(posedge clk_sys);
    serial_data_wr <= '{wr: 1'h1, wdata: 8'h6c};
    @(posedge clk_sys);
    serial_data_wr.wr <= 1'h0;
    for (i = 0; i < 8; i++) begin
      @(posedge txd);
      @(negedge clk_sys);
      w[i] = rxd_out;
      chk(rxd_oe, 9'h001);
    end
    chk(w[7:0], 9'h06c);
    repeat (20) @(negedge clk_sys);
    chk({rxd_oe, serial_control_reg[1]}, 9'h001);
    stop_test();
  end
endmodule
